/* File: tmz_timer0.sv */
`timescale 1ns/1ns
`default_nettype none
module tmz_timer0
  import tmz_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins and core signals
  input  wire logic        extCountIn,
  input  wire logic        wdtTickIn,
  output logic             wdtTick,
  output logic             wdtClear,
  output logic             overflowIrq
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  count_ff,  nxt_count;      // timer0_count
  logic [7:0]  intCtl_ff, nxt_intCtl;     // interrupt_control
  logic [7:0]  option_ff, nxt_option;     // option_config
  logic [7:0]  dirA_ff,   nxt_dirA;       // porta_direction
  logic        sleep_ff,  nxt_sleep;      // sleep level from the core
  logic [7:0]  pre_ff,    nxt_pre;        // shared prescaler, hidden
  logic [1:0]  phase_ff,  nxt_phase;      // instruction-cycle divider
  logic [1:0]  inhib_ff,  nxt_inhib;      // write inhibit count
  logic        sync1_ff,  sync2_ff, sync3_ff; // input synchroniser
  logic        edge_ff,   nxt_edge;       // edge pending until cycle boundary
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        slverr_ff, nxt_slverr;
  logic        wdTick_ff, nxt_wdTick;
  logic        wdClr_ff,  nxt_wdClr;
  logic        irq_ff,    nxt_irq;

  // ---------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------
  logic       accPhase;    // first access cycle, answer not yet given
  logic       wrAcc;       // write lands at the edge that samples pready high
  logic       rdAcc;       // read data captured one cycle before the answer
  logic       cntWrite;    // software writes the count
  logic       wdcWrite;    // software issues the watchdog clear
  logic       cycEn;       // one pulse per instruction cycle
  logic       srcTick;     // source event for the count or prescaler
  logic       extEdge;     // selected edge seen on the synchronised input
  logic       preToTmr;    // prescaler owned by the timer
  logic [7:0] preMask;     // prescaler bits forming the ratio
  logic       preWrap;     // prescaler output pulse
  logic       cntInc;      // count advances this cycle
  logic [2:0] rate;

  // a write takes effect only while the master sees pready high,
  // so an access that never completes can not change a register
  assign accPhase = psel && penable && !pready_ff;
  assign wrAcc    = psel && penable && pwrite && pready_ff;
  assign rdAcc    = accPhase && !pwrite;
  assign cntWrite = wrAcc && paddr == ADDR_COUNT;
  assign wdcWrite = wrAcc && paddr == ADDR_CTRL && pwdata[WDC_BIT];
  assign rate     = option_ff[2:0];
  assign preToTmr = !option_ff[PA_BIT];
  assign cycEn    = phase_ff == INSTR_DIV && !sleep_ff;

  // ---------------------------------------------------------------
  // edge detect on the synchronised input, second and third stages
  // ---------------------------------------------------------------
  always_comb
  begin
    // rising when edge select clear, falling when set
    if (option_ff[SE_BIT])
      extEdge = sync3_ff && !sync2_ff;
    else
      extEdge = !sync3_ff && sync2_ff;
  end

  // ---------------------------------------------------------------
  // timer source and prescaler
  // ---------------------------------------------------------------
  always_comb
  begin
    // pending edge held in counter mode only, consumed at the cycle boundary;
    // an edge seen on the boundary itself is counted there, never kept
    nxt_edge = option_ff[CS_BIT] && (edge_ff || extEdge);
    if (cycEn)
      nxt_edge = 1'b0;
    // timer source: instruction cycle or synchronised external edge
    if (option_ff[CS_BIT])
      srcTick = cycEn && (edge_ff || extEdge);
    else
      srcTick = cycEn;
    // ratio mask: timer 2^(n+1), watchdog 2^n
    if (preToTmr)
      preMask = 8'((9'h002 << rate) - 9'h001);
    else
      preMask = 8'((9'h001 << rate) - 9'h001);
    preWrap = (pre_ff & preMask) == preMask;
    // prescaler advances on its owner's event, cleared by its owner's count write or watchdog clear
    nxt_pre = pre_ff;
    if (preToTmr && srcTick)
      nxt_pre = pre_ff + 8'h01;
    else if (!preToTmr && wdtTickIn)
      nxt_pre = pre_ff + 8'h01;
    if (preToTmr && cntWrite)
      nxt_pre = 8'h00;
    else if (!preToTmr && wdcWrite)
      nxt_pre = 8'h00;
    // unassigned watchdog runs unscaled
    if (preToTmr)
      nxt_wdTick = wdtTickIn;
    else
      nxt_wdTick = wdtTickIn && preWrap;
    nxt_wdClr = wdcWrite;
    // timer increments: unscaled, or on prescaler output
    if (preToTmr)
      cntInc = srcTick && preWrap && inhib_ff == 2'h0;
    else
      cntInc = srcTick && inhib_ff == 2'h0;
  end

  // ---------------------------------------------------------------
  // divider, inhibit, count and flags
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_phase = phase_ff + 2'h1;
    // inhibit counts instruction cycles after a count write
    nxt_inhib = inhib_ff;
    if (cycEn && inhib_ff != 2'h0)
      nxt_inhib = inhib_ff - 2'h1;
    if (cntWrite)
      nxt_inhib = INHIBIT_CYC;
    nxt_count  = count_ff;
    nxt_intCtl = intCtl_ff;
    nxt_option = option_ff;
    nxt_dirA   = dirA_ff;
    nxt_sleep  = sleep_ff;
    if (cntInc)
      nxt_count = count_ff + 8'h01;
    // register writes; prescaler has no address
    if (wrAcc)
    begin
      unique case (paddr)
        ADDR_COUNT:  nxt_count  = pwdata[7:0];
        ADDR_INTCTL: nxt_intCtl = pwdata[7:0];
        ADDR_OPTION: nxt_option = pwdata[7:0];
        ADDR_DIRA:   nxt_dirA   = {2'h0, pwdata[5:0]};
        ADDR_CTRL:   nxt_sleep  = pwdata[SLP_BIT];
        default:     nxt_count  = nxt_count;
      endcase
    end
    // wrap sets the flag; set beats a simultaneous clear
    if (cntInc && count_ff == 8'hFF)
      nxt_intCtl[OF_BIT] = 1'b1;
    nxt_irq = nxt_intCtl[OF_BIT] && nxt_intCtl[OE_BIT];
  end

  // ---------------------------------------------------------------
  // apb answer: ready one cycle into the access phase
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_pready = accPhase;
    nxt_slverr = 1'b0;
    nxt_prdata = 32'h0000_0000;
    // decode once per transfer, in the first access cycle
    if (accPhase)
    begin
      unique case (paddr)
        ADDR_COUNT:  nxt_prdata = {24'h0, count_ff};
        ADDR_INTCTL: nxt_prdata = {24'h0, intCtl_ff};
        ADDR_OPTION: nxt_prdata = {24'h0, option_ff};
        ADDR_DIRA:   nxt_prdata = {24'h0, dirA_ff};
        ADDR_CTRL:   nxt_prdata = {31'h0, sleep_ff};
        default:     nxt_slverr = 1'b1;
      endcase
    end
    if (!rdAcc)
      nxt_prdata = 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      count_ff  <= COUNT_RST;
      intCtl_ff <= INTCTL_RST;
      option_ff <= OPTION_RST;
      dirA_ff   <= DIRA_RST;
      sleep_ff  <= 1'b0;
      pre_ff    <= 8'h00;
      phase_ff  <= 2'h0;
      inhib_ff  <= 2'h0;
      sync1_ff  <= 1'b0;
      sync2_ff  <= 1'b0;
      sync3_ff  <= 1'b0;
      edge_ff   <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      slverr_ff <= 1'b0;
      wdTick_ff <= 1'b0;
      wdClr_ff  <= 1'b0;
      irq_ff    <= 1'b0;
    end
    else
    begin
      count_ff  <= nxt_count;
      intCtl_ff <= nxt_intCtl;
      option_ff <= nxt_option;
      dirA_ff   <= nxt_dirA;
      sleep_ff  <= nxt_sleep;
      pre_ff    <= nxt_pre;
      phase_ff  <= nxt_phase;
      inhib_ff  <= nxt_inhib;
      sync1_ff  <= extCountIn;
      sync2_ff  <= sync1_ff;
      sync3_ff  <= sync2_ff;
      edge_ff   <= nxt_edge;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      slverr_ff <= nxt_slverr && nxt_pready;
      wdTick_ff <= nxt_wdTick;
      wdClr_ff  <= nxt_wdClr;
      irq_ff    <= nxt_irq;
    end
  end

  assign prdata      = prdata_ff;
  assign pready      = pready_ff;
  assign pslverr     = slverr_ff;
  assign wdtTick     = wdTick_ff;
  assign wdtClear    = wdClr_ff;
  assign overflowIrq = irq_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_flagOnWrap;
    @(posedge sys_clk) disable iff (!rst_n)
    (cntInc && count_ff == 8'hFF && !cntWrite) |=> (intCtl_ff[OF_BIT] && count_ff == 8'h00);
  endproperty
  a_flagOnWrap: assert property (p_flagOnWrap) else $error("wrap without flag");

  property p_flagIgnoresEnable;
    @(posedge sys_clk) disable iff (!rst_n)
    (cntInc && count_ff == 8'hFF && !intCtl_ff[OE_BIT] && !wrAcc) |=> intCtl_ff[OF_BIT];
  endproperty
  a_flagIgnoresEnable: assert property (p_flagIgnoresEnable) else $error("flag gated");

  property p_irqMask;
    @(posedge sys_clk) disable iff (!rst_n)
    (!intCtl_ff[OE_BIT] && !(wrAcc && paddr == ADDR_INTCTL)) |=> !overflowIrq;
  endproperty
  a_irqMask: assert property (p_irqMask) else $error("irq while masked");

  property p_inhibitCount;
    @(posedge sys_clk) disable iff (!rst_n)
    cntWrite |=> inhib_ff == 2'h2;
  endproperty
  a_inhibitCount: assert property (p_inhibitCount) else $error("inhibit not loaded");

  property p_noIncInhib;
    @(posedge sys_clk) disable iff (!rst_n)
    (inhib_ff != 2'h0 && !cntWrite) |=> count_ff == $past(count_ff);
  endproperty
  a_noIncInhib: assert property (p_noIncInhib) else $error("count during inhibit");

  property p_sleepStops;
    @(posedge sys_clk) disable iff (!rst_n)
    (sleep_ff && !wrAcc) |=> $stable(count_ff);
  endproperty
  a_sleepStops: assert property (p_sleepStops) else $error("count in sleep");

  property p_preClrTmr;
    @(posedge sys_clk) disable iff (!rst_n)
    (cntWrite && preToTmr) |=> pre_ff == 8'h00;
  endproperty
  a_preClrTmr: assert property (p_preClrTmr) else $error("prescaler kept");

  property p_preClrWdt;
    @(posedge sys_clk) disable iff (!rst_n)
    (wdcWrite && !preToTmr) |=> (pre_ff == 8'h00 && wdtClear);
  endproperty
  a_preClrWdt: assert property (p_preClrWdt) else $error("watchdog clear missed");

  property p_timerUnscaled;
    @(posedge sys_clk) disable iff (!rst_n)
    (!option_ff[CS_BIT] && !preToTmr && cycEn && inhib_ff == 2'h0 && !wrAcc)
      |=> count_ff == $past(count_ff) + 8'h01;
  endproperty
  a_timerUnscaled: assert property (p_timerUnscaled) else $error("timer missed cycle");

  property p_wdtUnscaled;
    @(posedge sys_clk) disable iff (!rst_n)
    (preToTmr && wdtTickIn) |=> wdtTick;
  endproperty
  a_wdtUnscaled: assert property (p_wdtUnscaled) else $error("watchdog scaled");

  property p_pready;
    @(posedge sys_clk) disable iff (!rst_n)
    (psel && penable && !pready) |=> pready;
  endproperty
  a_pready: assert property (p_pready) else $error("apb no answer");

  // counter mode: no selected edge, no count change
  property p_cntNeedsEdge;
    @(posedge sys_clk) disable iff (!rst_n)
    (option_ff[CS_BIT] && !edge_ff && !extEdge && !cntWrite) |=> $stable(count_ff);
  endproperty
  a_cntNeedsEdge: assert property (p_cntNeedsEdge) else $error("no edge");

  // a pending edge never survives the boundary that counts it
  property p_edgeUsed;
    @(posedge sys_clk) disable iff (!rst_n)
    (cycEn && option_ff[CS_BIT]) |=> !edge_ff;
  endproperty
  a_edgeUsed: assert property (p_edgeUsed) else $error("edge kept");

  // timer-owned prescaler never divides by less than two
  property p_tmrMinRatio;
    @(posedge sys_clk) disable iff (!rst_n)
    (preToTmr && srcTick && !pre_ff[0] && !cntWrite) |=> $stable(count_ff);
  endproperty
  a_tmrMinRatio: assert property (p_tmrMinRatio) else $error("ratio below 2");

  // watchdog-owned prescaler at rate zero passes every tick
  property p_wdtOneToOne;
    @(posedge sys_clk) disable iff (!rst_n)
    (!preToTmr && rate == 3'h0 && wdtTickIn) |=> wdtTick;
  endproperty
  a_wdtOneToOne: assert property (p_wdtOneToOne) else $error("tick lost");

  // only the 8-bit registers and the sleep bit are readable, the prescaler never shows
  property p_readHidden;
    @(posedge sys_clk) disable iff (!rst_n)
    rdAcc |=> prdata[31:8] == 24'h00_0000;
  endproperty
  a_readHidden: assert property (p_readHidden) else $error("upper bits set");

  // the flag stays until software writes the interrupt control
  property p_flagHold;
    @(posedge sys_clk) disable iff (!rst_n)
    (intCtl_ff[OF_BIT] && !(wrAcc && paddr == ADDR_INTCTL)) |=> intCtl_ff[OF_BIT];
  endproperty
  a_flagHold: assert property (p_flagHold) else $error("flag lost");
endmodule
`default_nettype wire

/* File: tmz_pkg.sv */
`default_nettype none
package tmz_pkg;
  // register offsets (printed offsets not all multiples of four: index times four)
  localparam logic [7:0]  IDX_COUNT   = 8'h01;
  localparam logic [7:0]  IDX_INTCTL  = 8'h0B;
  localparam logic [7:0]  IDX_OPTION  = 8'h81;
  localparam logic [7:0]  IDX_DIRA    = 8'h85;
  localparam logic [7:0]  IDX_CTRL    = 8'hC0;
  localparam logic [11:0] ADDR_COUNT  = {2'h0, IDX_COUNT, 2'h0};
  localparam logic [11:0] ADDR_INTCTL = {2'h0, IDX_INTCTL, 2'h0};
  localparam logic [11:0] ADDR_OPTION = {2'h0, IDX_OPTION, 2'h0};
  localparam logic [11:0] ADDR_DIRA   = {2'h0, IDX_DIRA, 2'h0};
  localparam logic [11:0] ADDR_CTRL   = {2'h0, IDX_CTRL, 2'h0};
  // option_config fields
  localparam int CS_BIT  = 5;
  localparam int SE_BIT  = 4;
  localparam int PA_BIT  = 3;
  // interrupt_control fields
  localparam int GIE_BIT = 7;
  localparam int OE_BIT  = 5;
  localparam int OF_BIT  = 2;
  // control register of our own: bit0 sleep, bit1 watchdog clear (write pulse)
  localparam int SLP_BIT = 0;
  localparam int WDC_BIT = 1;
  // reset values
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] DIRA_RST   = 8'h3F;
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  // timing: instruction cycle is four clocks, write inhibit is two cycles
  localparam int         CLK_MHZ      = 250;
  localparam int         INSTR_NS     = 16;
  localparam logic [1:0] INSTR_DIV    = 2'((INSTR_NS * CLK_MHZ) / 1000 - 1);
  localparam logic [1:0] INHIBIT_CYC  = 2'h2;
endpackage
`default_nettype wire

/* File: tmz_timer0_test.sv */
`timescale 1ns/1ns
`default_nettype none
module tmz_timer0_test;
  import tmz_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        sys_clk;          // 250 MHz clock
  logic        rst_n;            // sync reset, active low
  logic        psel;             // apb select
  logic        penable;          // apb access phase
  logic        pwrite;           // apb direction
  logic [11:0] paddr;            // apb byte address
  logic [31:0] pwdata;           // apb write data
  logic [31:0] prdata;           // apb read data
  logic        pready;           // apb answer
  logic        pslverr;          // apb error
  logic        extCountIn;       // external count input
  logic        wdtTickIn;        // watchdog base tick
  logic        wdtTick;          // scaled watchdog tick
  logic        wdtClear;         // watchdog clear pulse
  logic        overflowIrq;      // overflow request
  logic [31:0] rdData;           // last read data
  logic        rdErr;            // last error response
  int          tRd;              // cycle of last answer
  int          cyc = 0;          // free cycle counter
  int          nTick = 0;        // scaled ticks seen
  int          nClr = 0;         // clear pulses seen
  int          n_mismatch = 0;   // failed compares
  int          total_checks = 0; // compares made

  tmz_timer0 u_tmz_timer0 (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extCountIn(extCountIn), .wdtTickIn(wdtTickIn), .wdtTick(wdtTick),
    .wdtClear(wdtClear), .overflowIrq(overflowIrq));

  // clock generator, 4 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // counts cycles and output pulses
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (wdtTick === 1'b1) nTick <= nTick + 1;
    if (wdtClear === 1'b1) nClr <= nClr + 1;
  end

  // ----------------------------------------
  // compare, report and bus tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // exact compare of a value
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // compare of a count against a window
  task automatic check_rng(input string what, input int lo, input int hi, input logic [7:0] seen);
    total_checks++;
    if (((seen >= 8'(lo)) && (seen <= 8'(hi))) !== 1'b1)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rdData = prdata;
    rdErr  = pslverr;
    tRd    = cyc;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i >= 20)
    begin
      n_mismatch++;
      $display("CHECK FAILED pready expected 1 seen 0");
      close_out();
    end
  endtask

  // count delta over n clocks at ratio r (r 0 means stopped)
  task automatic span(input int n, input int r, input string what);
    logic [7:0] v0;
    int         t0;
    int         el;
    apb(1'b0, ADDR_COUNT, 32'h0);
    v0 = rdData[7:0];
    t0 = tRd;
    repeat (n) @(posedge sys_clk);
    apb(1'b0, ADDR_COUNT, 32'h0);
    el = tRd - t0;
    if (r == 0) check_rng(what, 0, 0, rdData[7:0] - v0);
    else check_rng(what, el / (4 * r), (el + 4 * r - 1) / (4 * r), rdData[7:0] - v0);
  endtask

  // base ticks into the watchdog path
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge sys_clk) wdtTickIn <= 1'b1;
      @(posedge sys_clk) wdtTickIn <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [11:0] adr [4] = '{ADDR_COUNT, ADDR_INTCTL, ADDR_OPTION, ADDR_DIRA};
    logic [7:0]  val [4] = '{COUNT_RST, INTCTL_RST, OPTION_RST, DIRA_RST};
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b0, adr[k], 32'h0);
      check("reset value", {24'h0, val[k]}, rdData);
    end
    apb(1'b1, ADDR_DIRA, 32'hFF);
    apb(1'b0, ADDR_DIRA, 32'h0);
    check("direction upper bits", 32'h3F, rdData);
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped error", 32'h1, {31'h0, rdErr});
    $display("reset and map test done");
  endtask

  task automatic t_timer();
    for (int ps = 0; ps < 8; ps++)
    begin
      apb(1'b1, ADDR_OPTION, 32'hC0 | ps);
      span(32 << ps, 2 << ps, "timer ratio");
    end
    apb(1'b1, ADDR_OPTION, 32'hC8);
    span(64, 1, "timer unscaled");
    apb(1'b1, ADDR_COUNT, 32'h40);
    rdErr = 1'b0;
    repeat (40) @(posedge sys_clk);
    apb(1'b0, ADDR_COUNT, 32'h0);
    // 42 edges hold 10 or 11 cycle enables, two of them blocked
    check_rng("count after write", 'h40 + 8, 'h40 + 9, rdData[7:0]);
    $display("timer ratio test done");
  endtask

  task automatic t_inhibit();
    int tw;
    apb(1'b1, ADDR_OPTION, 32'hC8);
    apb(1'b1, ADDR_COUNT, 32'h40);
    tw = tRd;
    repeat (40) @(posedge sys_clk);
    apb(1'b0, ADDR_COUNT, 32'h0);
    check_rng("count after write", 'h40 + (tRd - tw) / 4 - 3, 'h40 + (tRd - tw + 3) / 4 - 2,
      rdData[7:0]);
    apb(1'b1, ADDR_OPTION, 32'hC7);
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, ADDR_COUNT, 32'h0);
      repeat (800) @(posedge sys_clk);
      apb(1'b0, ADDR_COUNT, 32'h0);
      check("count with cleared prescaler", 32'h0, rdData);
    end
    $display("write inhibit test done");
  endtask

  task automatic t_extern();
    logic [7:0] v0;
    for (int se = 0; se < 2; se++)
    begin
      apb(1'b1, ADDR_OPTION, se ? 32'hF8 : 32'hE8);
      apb(1'b0, ADDR_COUNT, 32'h0);
      v0 = rdData[7:0];
      repeat (3)
      begin
        extCountIn <= 1'b1;
        repeat (16) @(posedge sys_clk);
        extCountIn <= 1'b0;
        repeat (16) @(posedge sys_clk);
      end
      extCountIn <= 1'b1;
      repeat (16) @(posedge sys_clk);
      apb(1'b0, ADDR_COUNT, 32'h0);
      check("edge count", se ? 32'h3 : 32'h4,
        {24'h0, rdData[7:0] - v0});
      extCountIn <= 1'b0;
      repeat (16) @(posedge sys_clk);
    end
    $display("external edge test done");
  endtask

  task automatic t_watchdog();
    int n0;
    for (int ps = 0; ps < 4; ps++)
    begin
      apb(1'b1, ADDR_OPTION, 32'hC8 | ps);
      apb(1'b1, ADDR_CTRL, 32'h2);
      n0 = nTick;
      ticks(4 << ps);
      check("watchdog ticks", 32'h4, 32'(nTick - n0));
    end
    n0 = nClr;
    // six ticks at 1:8: without the clear, three more would wrap once
    ticks(6);
    apb(1'b1, ADDR_CTRL, 32'h2);
    repeat (3) @(posedge sys_clk);
    check("clear pulses", 32'h1, 32'(nClr - n0));
    n0 = nTick;
    ticks(3);
    check("ticks after clear", 32'h0, 32'(nTick - n0));
    apb(1'b1, ADDR_OPTION, 32'hC0);
    n0 = nTick;
    ticks(4);
    check("watchdog unscaled", 32'h4, 32'(nTick - n0));
    $display("watchdog prescaler test done");
  endtask

  task automatic t_overflow();
    // prescaler and watchdog cleared before the owner moves to the watchdog
    apb(1'b1, ADDR_COUNT, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b1, ADDR_OPTION, 32'hC8);
    apb(1'b1, ADDR_INTCTL, 32'h80);
    apb(1'b1, ADDR_COUNT, 32'hFD);
    repeat (40) @(posedge sys_clk);
    apb(1'b0, ADDR_INTCTL, 32'h0);
    check("flag while masked", 32'h84, rdData);
    check("request while masked", 32'h0, {31'h0, overflowIrq});
    apb(1'b1, ADDR_INTCTL, 32'h20);
    repeat (2) @(posedge sys_clk);
    check("request after clear", 32'h0, {31'h0, overflowIrq});
    apb(1'b1, ADDR_COUNT, 32'hFD);
    repeat (40) @(posedge sys_clk);
    check("request enabled", 32'h1, {31'h0, overflowIrq});
    apb(1'b0, ADDR_INTCTL, 32'h0);
    check("flag enabled", 32'h24, rdData);
    apb(1'b1, ADDR_INTCTL, 32'h04);
    repeat (2) @(posedge sys_clk);
    check("request masked again", 32'h0, {31'h0, overflowIrq});
    $display("overflow test done");
  endtask

  task automatic t_sleep();
    apb(1'b1, ADDR_CTRL, 32'h1);
    span(64, 0, "count in sleep");
    apb(1'b1, ADDR_CTRL, 32'h0);
    span(64, 1, "count after wake");
    $display("sleep test done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst_n      = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    extCountIn = 1'b0;
    wdtTickIn  = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_timer();
    t_inhibit();
    t_extern();
    t_watchdog();
    t_overflow();
    t_sleep();
    close_out();
  end
endmodule
`default_nettype wire
